/* hdl/sector_protection_control.sv */
`include "spc_regs.svh"
module sector_protection_control import spc_pkg::*; #(
  parameter int MAP_ERASE_CYCLES = `SPC_MAP_ERASE_CYC
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       si,
  input  wire logic       wp_n,
  input  wire logic       req_valid,
  input  wire logic [4:0] req_sector,
  input  wire logic [9:0] req_page,
  input  wire logic       req_map,
  output logic            req_grant,
  output logic            req_deny,
  output logic            ready,
  output logic            prot_enabled,
  output logic            sw_prot_enabled,
  output logic            guard_active
);
  localparam int TW       = $clog2(MAP_ERASE_CYCLES + 1);
  localparam int EN_FILT  = `SPC_GUARD_ENABLE_CYC - `SPC_SYNC_LATENCY;
  localparam int REL_FILT = `SPC_GUARD_RELEASE_CYC - `SPC_SYNC_LATENCY;

  logic [2:0]  sck_sync_reg;
  logic [2:0]  cs_sync_reg;
  logic [2:0]  si_sync_reg;
  logic [2:0]  wp_sync_reg;
  logic        sck_st_reg;
  logic        cs_st_reg;
  logic        wp_raw_low_reg;
  logic        sck_rise;
  logic        cs_fall;
  logic        cs_rise;
  logic [31:0] shift_reg;
  logic [5:0]  bit_cnt_reg;
  logic        seq_ok;
  logic        cmd_enable;
  logic        cmd_disable;
  logic        cmd_erase;
  logic [7:0]  filt_cnt_reg;
  logic        erase_start;
  erase_st_t   erase_st_reg;
  logic [TW-1:0] erase_cnt_reg;
  logic [4:0]  fill_addr_reg;
  check_st_t   check_st_reg;
  logic [4:0]  ck_sector_reg;
  logic [9:0]  ck_page_reg;
  logic        ck_map_reg;
  logic        marked;
  logic        deny_next;

  map_if #(.AW(`SPC_MAP_AW), .DW(`SPC_MAP_DW)) map_bus ();

  prot_map #(
    .ENTRIES (`SPC_MAP_ENTRIES),
    .AW      (`SPC_MAP_AW),
    .DW      (`SPC_MAP_DW)
  ) u_map (
    .mclk (mclk),
    .nrst (nrst),
    .port (map_bus.mem)
  );

  // Three-stage synchronisers for all pins
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sck_sync_reg <= 3'h0;
      cs_sync_reg  <= 3'h7;
      si_sync_reg  <= 3'h0;
      wp_sync_reg  <= 3'h7;
    end else begin
      sck_sync_reg <= {sck_sync_reg[1:0], sck};
      cs_sync_reg  <= {cs_sync_reg[1:0], cs_n};
      si_sync_reg  <= {si_sync_reg[1:0], si};
      wp_sync_reg  <= {wp_sync_reg[1:0], wp_n};
    end
  end

  // Settled pin levels, updated once stages two and three agree
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sck_st_reg     <= 1'b0;
      cs_st_reg      <= 1'b1;
      wp_raw_low_reg <= 1'b0;
    end else begin
      if (sck_sync_reg[1] == sck_sync_reg[2]) begin
        sck_st_reg <= sck_sync_reg[2];
      end
      if (cs_sync_reg[1] == cs_sync_reg[2]) begin
        cs_st_reg <= cs_sync_reg[2];
      end
      if (wp_sync_reg[1] == wp_sync_reg[2]) begin
        wp_raw_low_reg <= ~wp_sync_reg[2];
      end
    end
  end

  // Edges of the settled serial clock and select
  assign sck_rise = (sck_sync_reg[1] == sck_sync_reg[2]) && sck_sync_reg[2] && !sck_st_reg;
  assign cs_fall  = (cs_sync_reg[1] == cs_sync_reg[2]) && !cs_sync_reg[2] && cs_st_reg;
  assign cs_rise  = (cs_sync_reg[1] == cs_sync_reg[2]) && cs_sync_reg[2] && !cs_st_reg;

  // Shift in bits on rising serial clock, count saturates past 32
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      shift_reg   <= 32'h0;
      bit_cnt_reg <= 6'h00;
    end else if (cs_fall) begin
      bit_cnt_reg <= 6'h00;
    end else if (!cs_st_reg && sck_rise) begin
      shift_reg <= {shift_reg[30:0], si_sync_reg[2]};
      if (bit_cnt_reg <= `SPC_CMD_BITS) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
    end
  end

  // Decode only exactly four bytes, at select release
  assign seq_ok = cs_rise && (bit_cnt_reg == `SPC_CMD_BITS)
               && shift_reg[31:24] == `SPC_PREFIX0
               && shift_reg[23:16] == `SPC_PREFIX1
               && shift_reg[15:8]  == `SPC_PREFIX2;
  assign cmd_enable  = seq_ok && shift_reg[7:0] == `SPC_OP_ENABLE;
  assign cmd_disable = seq_ok && shift_reg[7:0] == `SPC_OP_DISABLE;
  assign cmd_erase   = seq_ok && shift_reg[7:0] == `SPC_OP_MAP_ERASE;

  // Guard filter: level must hold for the filter length to count
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      filt_cnt_reg <= 8'h00;
      guard_active <= 1'b0;
    end else if (wp_raw_low_reg == guard_active) begin
      filt_cnt_reg <= 8'h00;
    end else if (guard_active == 1'b0 && filt_cnt_reg >= 8'(EN_FILT - 1)) begin
      filt_cnt_reg <= 8'h00;
      guard_active <= 1'b1;
    end else if (guard_active == 1'b1 && filt_cnt_reg >= 8'(REL_FILT - 1)) begin
      filt_cnt_reg <= 8'h00;
      guard_active <= 1'b0;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 8'h01;
    end
  end

  // Software protection state, disable ignored under guard
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sw_prot_enabled <= 1'b0;
    end else if (cmd_enable) begin
      sw_prot_enabled <= 1'b1;
    end else if (cmd_disable && !guard_active) begin
      sw_prot_enabled <= 1'b0;
    end
  end

  // Effective protection: guard only forces it, never clears software state
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prot_enabled <= 1'b0;
    end else begin
      prot_enabled <= sw_prot_enabled || guard_active;
    end
  end

  // Map erase accepted unless guard held or already busy
  assign erase_start = cmd_erase && !guard_active && erase_st_reg == ER_IDLE;

  // Map erase: write erased value to every entry, then wait out the time
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      erase_st_reg  <= ER_IDLE;
      erase_cnt_reg <= '0;
      fill_addr_reg <= 5'h00;
      ready         <= 1'b1;
    end else begin
      case (erase_st_reg)
        ER_IDLE: begin
          if (erase_start) begin
            erase_st_reg  <= ER_FILL;
            erase_cnt_reg <= '0;
            fill_addr_reg <= 5'h00;
            ready         <= 1'b0;
          end
        end
        ER_FILL: begin
          erase_cnt_reg <= erase_cnt_reg + TW'(1);
          fill_addr_reg <= fill_addr_reg + 5'h01;
          if (fill_addr_reg == 5'(`SPC_MAP_ENTRIES - 1)) begin
            erase_st_reg <= ER_WAIT;
          end
        end
        ER_WAIT: begin
          erase_cnt_reg <= erase_cnt_reg + TW'(1);
          if (erase_cnt_reg >= TW'(MAP_ERASE_CYCLES - 2)) begin
            erase_st_reg <= ER_IDLE;
            ready        <= 1'b1;
          end
        end
        default: begin
          erase_st_reg <= ER_IDLE;
          ready        <= 1'b1;
        end
      endcase
    end
  end

  // Map write port driven by the erase sequencer only
  assign map_bus.we    = erase_st_reg == ER_FILL;
  assign map_bus.waddr = fill_addr_reg;
  assign map_bus.wdata = `SPC_MAP_ERASED;
  assign map_bus.raddr = ck_sector_reg;

  // Protection mark from the map byte of the latched request
  always_comb begin
    marked = 1'b0;
    if (ck_sector_reg == 5'h00) begin
      if (ck_page_reg <= `SPC_SUB0A_LAST_PAGE) begin
        marked = &map_bus.rdata[`SPC_SUB0A_HI:`SPC_SUB0A_LO];
      end else begin
        marked = &map_bus.rdata[`SPC_SUB0B_HI:`SPC_SUB0B_LO];
      end
    end else begin
      marked = map_bus.rdata == `SPC_MAP_ERASED;
    end
  end

  always_comb begin
    if (!ready) begin
      deny_next = 1'b1;
    end else if (ck_map_reg) begin
      deny_next = guard_active;
    end else begin
      deny_next = prot_enabled && marked;
    end
  end

  // Request checker: latch, fetch map byte, decide
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      check_st_reg  <= CK_IDLE;
      ck_sector_reg <= 5'h00;
      ck_page_reg   <= 10'h000;
      ck_map_reg    <= 1'b0;
      req_grant     <= 1'b0;
      req_deny      <= 1'b0;
    end else begin
      req_grant <= 1'b0;
      req_deny  <= 1'b0;
      case (check_st_reg)
        CK_IDLE: begin
          if (req_valid) begin
            ck_sector_reg <= req_sector;
            ck_page_reg   <= req_page;
            ck_map_reg    <= req_map;
            check_st_reg  <= CK_FETCH;
          end
        end
        CK_FETCH: begin
          check_st_reg <= CK_DECIDE;
        end
        CK_DECIDE: begin
          req_grant    <= !deny_next;
          req_deny     <= deny_next;
          check_st_reg <= CK_IDLE;
        end
        default: begin
          check_st_reg <= CK_IDLE;
        end
      endcase
    end
  end

  chk_enable_sets: assert property (@(posedge mclk) disable iff (!nrst)
    cmd_enable |=> sw_prot_enabled ##1 prot_enabled)
    else $error("enable command did not set protection");

  chk_disable_clears: assert property (@(posedge mclk) disable iff (!nrst)
    cmd_disable && !guard_active |=> !sw_prot_enabled)
    else $error("disable command did not clear protection");

  chk_disable_guarded: assert property (@(posedge mclk) disable iff (!nrst)
    cmd_disable && guard_active && !cmd_enable |=> $stable(sw_prot_enabled))
    else $error("disable acted while guard asserted");

  chk_short_seq: assert property (@(posedge mclk) disable iff (!nrst)
    cs_rise && bit_cnt_reg != `SPC_CMD_BITS |=> $stable(sw_prot_enabled)
      && !(erase_st_reg == ER_FILL && $past(erase_st_reg) == ER_IDLE))
    else $error("incomplete sequence changed state");

  chk_guard_forces: assert property (@(posedge mclk) disable iff (!nrst)
    guard_active |=> prot_enabled)
    else $error("guard did not force protection on");

  chk_guard_glitch: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(guard_active) |-> $past(wp_raw_low_reg, 1) == guard_active
      && $past(wp_raw_low_reg, 6) == guard_active)
    else $error("short guard pulse changed guard state");

  chk_erase_busy: assert property (@(posedge mclk) disable iff (!nrst)
    erase_start |=> !ready [*8])
    else $error("ready during map erase");

  chk_erase_fill: assert property (@(posedge mclk) disable iff (!nrst)
    erase_start |=> map_bus.we && map_bus.waddr == 5'h00 ##31 map_bus.we ##1 !map_bus.we)
    else $error("map erase fill sequence wrong");

  chk_map_guard: assert property (@(posedge mclk) disable iff (!nrst)
    check_st_reg == CK_DECIDE && ck_map_reg && guard_active |=> req_deny && !req_grant)
    else $error("map change granted under guard");

  chk_unprotected: assert property (@(posedge mclk) disable iff (!nrst)
    check_st_reg == CK_DECIDE && !ck_map_reg && !prot_enabled && ready |=> req_grant)
    else $error("request denied with protection off");

  // A map erase must not start while the guard pin is asserted
  chk_erase_guarded: assert property (@(posedge mclk) disable iff (!nrst)
    cmd_erase && guard_active && erase_st_reg == ER_IDLE |=> erase_st_reg == ER_IDLE && ready)
    else $error("map erase started under guard");

  // Every decided request gives exactly one answer pulse
  chk_one_answer: assert property (@(posedge mclk) disable iff (!nrst)
    check_st_reg == CK_DECIDE |=> req_grant != req_deny)
    else $error("request answer missing or doubled");
endmodule // sector_protection_control

/* hdl/spc_regs.svh */
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// Clock and timing
`define SPC_CLK_PERIOD_NS          100
`define SPC_GUARD_ENABLE_DELAY_NS  1000
`define SPC_GUARD_RELEASE_DELAY_NS 1000
`define SPC_MAP_ERASE_TIME_NS      2000000
`define SPC_GUARD_ENABLE_CYC       (`SPC_GUARD_ENABLE_DELAY_NS / `SPC_CLK_PERIOD_NS)
`define SPC_GUARD_RELEASE_CYC      (`SPC_GUARD_RELEASE_DELAY_NS / `SPC_CLK_PERIOD_NS)
`define SPC_MAP_ERASE_CYC          (`SPC_MAP_ERASE_TIME_NS / `SPC_CLK_PERIOD_NS)
`define SPC_SYNC_LATENCY           4

// Command sequence bytes
`define SPC_PREFIX0                8'h3d
`define SPC_PREFIX1                8'h2a
`define SPC_PREFIX2                8'h7f
`define SPC_OP_ENABLE              8'ha9
`define SPC_OP_DISABLE             8'h9a
`define SPC_OP_MAP_ERASE           8'hcf
`define SPC_CMD_BITS               6'd32

// Protection map layout
`define SPC_MAP_ENTRIES            32
`define SPC_MAP_AW                 5
`define SPC_MAP_DW                 8
`define SPC_MAP_ERASED             8'hff
`define SPC_MAP_FACTORY            8'h00
`define SPC_SUB0A_HI               7
`define SPC_SUB0A_LO               6
`define SPC_SUB0B_HI               5
`define SPC_SUB0B_LO               4
`define SPC_SUB0A_LAST_PAGE        10'h007

`endif

/* hdl/spc_pkg.sv */
package spc_pkg;
  typedef enum logic [1:0] {ER_IDLE, ER_FILL, ER_WAIT} erase_st_t;
  typedef enum logic [1:0] {CK_IDLE, CK_FETCH, CK_DECIDE} check_st_t;
endpackage

/* hdl/map_if.sv */
interface map_if #(parameter int AW = 5, parameter int DW = 8);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, waddr, wdata, raddr, input rdata);
  modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface

/* hdl/prot_map.sv */
`include "spc_regs.svh"
module prot_map import spc_pkg::*; #(
  parameter int ENTRIES = `SPC_MAP_ENTRIES,
  parameter int AW      = `SPC_MAP_AW,
  parameter int DW      = `SPC_MAP_DW
) (
  input wire logic mclk,
  input wire logic nrst,
  map_if.mem       port
);
  logic [DW-1:0] entry_reg [ENTRIES];

  // One byte per sector, factory value all unmarked
  genvar i;
  generate
    for (i = 0; i < ENTRIES; i++) begin : g_entry
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          entry_reg[i] <= DW'(`SPC_MAP_FACTORY);
        end else if (port.we && port.waddr == AW'(i)) begin
          entry_reg[i] <= port.wdata;
        end
      end
    end
  endgenerate

  // Registered read port
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      port.rdata <= '0;
    end else begin
      port.rdata <= entry_reg[port.raddr];
    end
  end
endmodule // prot_map

/* testbench/spi_host_model.sv */
module spi_host_model (
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic [31:0] word,
  input  wire logic [5:0]  nbits,
  input  wire logic [3:0]  hold,
  output logic             sck,
  output logic             cs_n,
  output logic             si,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle with clock parked low and deselected; one select frame per go pulse,
  // each clock phase lasting hold cycles
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge mclk);
      if (go) begin
        #1;
        busy = 1'b1;
        cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
          si = word[31-i];
          repeat (hold) @(posedge mclk);
          #1 sck = 1'b1;
          repeat (hold) @(posedge mclk);
          #1 sck = 1'b0;
        end
        repeat (hold) @(posedge mclk);
        #1 cs_n = 1'b1;
        repeat (hold) @(posedge mclk);
        #1 busy = 1'b0;
      end else begin
        #1 si = ~si; // Released line toggles so no stale bit is seen
      end
    end
  end
endmodule // spi_host_model

/* testbench/test_sector_protection_control.sv */
`include "spc_regs.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module test_sector_protection_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ERASE_CYC = 64;
  localparam logic [23:0] PRE = {`SPC_PREFIX0, `SPC_PREFIX1, `SPC_PREFIX2};
  localparam logic [31:0] ENA = {PRE, `SPC_OP_ENABLE};
  localparam logic [31:0] DIS = {PRE, `SPC_OP_DISABLE};
  localparam logic [31:0] ERA = {PRE, `SPC_OP_MAP_ERASE};
  logic        mclk, nrst, sck, cs_n, si, wp_n, go, busy;
  logic        req_valid, req_map, req_grant, req_deny, ready, prot_enabled, sw_prot_enabled, guard_active;
  logic [4:0]  req_sector;
  logic [9:0]  req_page;
  logic [31:0] word;
  logic [5:0]  nbits;
  logic [3:0]  hold;
  logic        e_busy, e_guard, e_prot, marked;
  int          fails, check_count, n;

  sector_protection_control #(.MAP_ERASE_CYCLES(ERASE_CYC)) u_sector_protection_control (
    .mclk(mclk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .req_valid(req_valid),
    .req_sector(req_sector), .req_page(req_page), .req_map(req_map), .req_grant(req_grant),
    .req_deny(req_deny), .ready(ready), .prot_enabled(prot_enabled), .sw_prot_enabled(sw_prot_enabled),
    .guard_active(guard_active));

  spi_host_model u_spi_host_model (
    .mclk(mclk), .go(go), .word(word), .nbits(nbits), .hold(hold), .sck(sck), .cs_n(cs_n), .si(si), .busy(busy));

  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Watchdog against a hung handshake
  initial begin
    #(60000 * 100);
    fails++;
    close_out();
  end

  task automatic close_out();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  // Expected decision of the sector check
  function automatic logic exp_deny(input logic m);
    if (e_busy) return 1'b1;
    if (m) return e_guard;
    return e_prot & marked;
  endfunction

  // One framed command from the host model, random clock phase length
  task automatic send(input logic [31:0] w, input logic [5:0] b);
    word = w;
    nbits = b;
    hold = 4'(5 + $urandom % 4);
    go = 1'b1;
    tick();
    go = 1'b0;
    tick();
    n = 0;
    while (busy && n < 800) begin
      tick();
      n++;
    end
    tick();
  endtask

  // Check request: answer pulse stands in the cycle after the second edge past the take
  task automatic chk_req(input logic [4:0] s, input logic [9:0] p, input logic m);
    logic e;
    e = exp_deny(m);
    req_sector = s;
    req_page = p;
    req_map = m;
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
    repeat (2) tick();
    `CHK("req_deny", e, req_deny);
    `CHK("req_grant", ~e, req_grant);
    tick();
  endtask

  // Wait for a status output to reach a level, bounded
  task automatic wait_lvl(input int w, input logic v, input int lim);
    n = 0;
    while (n < lim && (w == 0 ? guard_active : w == 1 ? prot_enabled : ready) !== v) begin
      tick();
      n++;
    end
  endtask

  task automatic guard(input logic low);
    wp_n = ~low;
    e_guard = low;
    wait_lvl(0, low, 11);
    `CHK("guard_active", low, guard_active);
    tick();
    tick();
  endtask

  // Main sequence
  initial begin
    {nrst, go, req_valid, req_map, e_busy, e_guard, e_prot, marked} = '0;
    {wp_n, hold, nbits, word, req_sector, req_page} = '1;
    fails = 0;
    check_count = 0;
    void'($urandom(78));
    repeat (12) tick();
    nrst = 1'b1;
    tick();
    `CHK("ready", 1'b1, ready);
    `CHK("sw_prot", 1'b0, sw_prot_enabled);
    `CHK("prot", 1'b0, prot_enabled);
    send(ENA, `SPC_CMD_BITS);
    e_prot = 1'b1;
    `CHK("sw_prot", 1'b1, sw_prot_enabled);
    `CHK("prot", 1'b1, prot_enabled);
    for (int i = 0; i < 6; i++) chk_req(5'($urandom), 10'($urandom), 1'b0);
    chk_req(5'd0, 10'd0, 1'b1);
    send(ERA, `SPC_CMD_BITS);
    e_busy = 1'b1;
    `CHK("ready", 1'b0, ready);
    chk_req(5'($urandom), 10'($urandom), 1'b0);
    wait_lvl(2, 1'b1, 200);
    `CHK("erase_len", 1'b1, n > ERASE_CYC - 20 && n <= ERASE_CYC);
    e_busy = 1'b0;
    marked = 1'b1;
    for (int s = 0; s < 32; s++) chk_req(5'(s), 10'($urandom), 1'b0);
    chk_req(5'd0, 10'd7, 1'b0);
    chk_req(5'd0, 10'd8, 1'b0);
    send(DIS, 6'd31);
    send({PRE, 8'h30}, `SPC_CMD_BITS);
    send(DIS, 6'd24);
    `CHK("sw_prot", 1'b1, sw_prot_enabled);
    send(DIS, `SPC_CMD_BITS);
    e_prot = 1'b0;
    `CHK("prot", 1'b0, prot_enabled);
    chk_req(5'($urandom), 10'($urandom), 1'b0);
    for (int k = 0; k < 4; k++) begin
      wp_n = 1'b0;
      repeat (1 + $urandom % 4) tick();
      wp_n = 1'b1;
      repeat (20) tick();
      `CHK("glitch", 1'b0, guard_active);
    end
    guard(1'b1);
    e_prot = 1'b1;
    `CHK("prot", 1'b1, prot_enabled);
    `CHK("sw_prot", 1'b0, sw_prot_enabled);
    chk_req(5'd1, 10'd0, 1'b1);
    send(ERA, `SPC_CMD_BITS);
    `CHK("ready", 1'b1, ready);
    chk_req(5'($urandom), 10'($urandom), 1'b0);
    guard(1'b0);
    e_prot = 1'b0;
    `CHK("prot", 1'b0, prot_enabled);
    send(ENA, `SPC_CMD_BITS);
    guard(1'b1);
    send(DIS, `SPC_CMD_BITS);
    `CHK("sw_prot", 1'b1, sw_prot_enabled);
    guard(1'b0);
    `CHK("prot", 1'b1, prot_enabled);
    send(DIS, `SPC_CMD_BITS);
    guard(1'b1);
    send(ENA, `SPC_CMD_BITS);
    guard(1'b0);
    `CHK("prot", 1'b1, prot_enabled);
    send(DIS, `SPC_CMD_BITS);
    `CHK("prot", 1'b0, prot_enabled);
    // Reset in mid-run: software state drops, map returns to unmarked
    send(ENA, `SPC_CMD_BITS);
    nrst = 1'b0;
    repeat (12) tick();
    nrst = 1'b1;
    tick();
    `CHK("sw_prot", 1'b0, sw_prot_enabled);
    `CHK("prot", 1'b0, prot_enabled);
    `CHK("ready", 1'b1, ready);
    send(ENA, `SPC_CMD_BITS);
    e_prot = 1'b1;
    marked = 1'b0;
    chk_req(5'($urandom), 10'($urandom), 1'b0);
    close_out();
  end
endmodule // test_sector_protection_control
